// ===== cnt_meas_regs.svh
// register offsets, field positions, reset values and sizes of the measurement counter pair
`ifndef CNT_MEAS_REGS_SVH
`define CNT_MEAS_REGS_SVH

`define ADDR_W        8
`define DATA_W        32
`define CNT_W         32
`define TERM_N        8
`define TERM_SEL_W    3

`define OFF_CTRL      8'h00
`define OFF_CONFIG    8'h04
`define OFF_DIVIDE    8'h08
`define OFF_GATE      8'h0c
`define OFF_STATUS    8'h10
`define OFF_RESULT_A  8'h14
`define OFF_RESULT_B  8'h18

`define CTRL_START    0
`define CTRL_STOP     1

`define STAT_BUSY     0
`define STAT_VALID    1
`define STAT_OVF      2
`define STAT_LOST     3
`define STAT_EMPTY    4

`define CFG_W         28
`define CFG_RESET     28'h0000000
`define DIV_RESET     32'h00000001
`define CLK_MHZ       10
`define GATE_RESET_US 1000
`define GATE_RESET    (32'(`GATE_RESET_US * `CLK_MHZ))

`define TB_INTERNAL   4'h0
`define CNT_ZERO      32'h00000000
`define CNT_ONE       32'h00000001
`define CNT_MAX       32'hffffffff

`define FIFO_AW       4
`define RES_W         64

`endif

// ===== cnt_meas_pkg.sv
// types shared by the measurement counter pair and its result memory
package cnt_meas_pkg;

  typedef enum logic [1:0] {
    KIND_FREQ   = 2'b00,
    KIND_PERIOD = 2'b01,
    KIND_WIDTH  = 2'b10
  } meas_kind_t;

  typedef enum logic [1:0] {
    METH_LOW_ONE     = 2'b00,
    METH_LARGE_RANGE = 2'b01,
    METH_HIGH_FREQ   = 2'b10
  } freq_method_t;

  typedef enum logic [1:0] {
    TIME_ON_DEMAND = 2'b00,
    TIME_IMPLICIT  = 2'b01,
    TIME_SAMPLE    = 2'b10
  } timing_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARM  = 3'b001,
    ST_SYNC = 3'b010,
    ST_MEAS = 3'b011,
    ST_HOLD = 3'b100
  } state_t;

  typedef struct packed {
    logic [2:0]   sample_clock_select;
    logic         arm_trigger_polarity;
    logic [2:0]   arm_trigger_source;
    logic         arm_trigger_type;
    logic         width_start_edge;
    logic [3:0]   timebase_source_select;
    logic [2:0]   width_input_select;
    logic [2:0]   period_input_select;
    logic [2:0]   freq_input_select;
    timing_t      timing;
    freq_method_t freq_method_select;
    meas_kind_t   kind;
  } config_t;

  typedef struct packed {
    logic [31:0] divided_period_count;
    logic [31:0] timebase_cycle_count;
  } result_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

endpackage

// ===== cnt_result_mem.sv
// result buffer storage: one write port, registered read port
`include "cnt_meas_regs.svh"

module cnt_result_mem (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // write side
  input  wire logic                  i_wr_en,
  input  wire logic [`FIFO_AW-1:0]   i_wr_addr,
  input  wire cnt_meas_pkg::result_t i_wr_data,
  // read side
  input  wire logic [`FIFO_AW-1:0]   i_rd_addr,
  output cnt_meas_pkg::result_t      o_rd_data
);
  import cnt_meas_pkg::*;

  result_t mem [0:(1<<`FIFO_AW)-1];

  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // a word written at this edge is not seen until the next one
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= result_t'(`RES_W'h0);
    end else begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule

// ===== counter_freq_pulse_measure.sv
// counter pair for frequency, period and pulse-width measurement
//
// Behaviour
// R1 - one counter times first full input period
// R2 - default timebase is the onboard clock
// R3 - first counter gates over programmed whole periods
// R4 - partner counts timebase across divided pulse
// R5 - large range returns both counts
// R6 - period divide factor is software set
// R7 - only fixed even-odd counter pairs used
// R8 - one counter makes timed gate for other
// R9 - receiver counts input periods during gate
// R10 - gate time is software set
// R11 - period uses frequency hardware, reciprocal result
// R12 - width counts timebase while input active
// R13 - armed mid-pulse waits for next pulse
// R14 - selectable starting edge, rising by default
// R15 - on-demand: measure, hold, resume after read
// R16 - implicit: every result appended to buffer
// R17 - sample clock stores latest complete result
// R18 - start by software or arm edge trigger
// R19 - arm trigger mid-pulse measures next pulse
// R20 - input and timebase selectable from terminals
// R21 - flag counter overflow and lost results
`include "cnt_meas_regs.svh"

module counter_freq_pulse_measure (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // register port
  input  wire cnt_meas_pkg::bus_req_t i_bus,
  output logic [`DATA_W-1:0]          o_rd_data,
  // programmable input terminals
  input  wire logic [`TERM_N-1:0]     i_terminals,
  // observation
  output logic                        o_gate,
  output logic                        o_busy
);
  import cnt_meas_pkg::*;

  logic [`TERM_N-1:0]  term_meta_reg;
  logic [`TERM_N-1:0]  term_sync_reg;
  logic [`TERM_N-1:0]  term_prev_reg;
  config_t             cfg_reg;
  logic [`CNT_W-1:0]   divide_reg;
  logic [`CNT_W-1:0]   gate_time_reg;
  state_t              state_reg;
  state_t              state_next;
  logic [`CNT_W-1:0]   tb_cnt_reg;
  logic [`CNT_W-1:0]   tb_cnt_next;
  logic [`CNT_W-1:0]   per_cnt_reg;
  logic [`CNT_W-1:0]   per_cnt_next;
  result_t             res_reg;
  result_t             res_next;
  logic                have_res_reg;
  logic                ovf_reg;
  logic                lost_reg;
  logic                gate_reg;
  logic [`FIFO_AW:0]   wr_ptr_reg;
  logic [`FIFO_AW:0]   rd_ptr_reg;
  logic [`FIFO_AW:0]   rd_ptr_next;
  logic                stale_reg;
  result_t             head_data;
  logic                done;
  logic                ovf_set;
  logic [`CNT_W-1:0]   tb_inc;
  logic [`DATA_W-1:0]  rd_mux;

  // bus decode
  wire wr_ctrl   = i_bus.wr && (i_bus.addr == `OFF_CTRL);
  wire wr_config = i_bus.wr && (i_bus.addr == `OFF_CONFIG);
  wire wr_divide = i_bus.wr && (i_bus.addr == `OFF_DIVIDE);
  wire wr_gate   = i_bus.wr && (i_bus.addr == `OFF_GATE);
  wire wr_status = i_bus.wr && (i_bus.addr == `OFF_STATUS);
  wire rd_res_a  = i_bus.rd && (i_bus.addr == `OFF_RESULT_A);
  wire start_cmd = wr_ctrl && i_bus.wdata[`CTRL_START];
  wire stop_cmd  = wr_ctrl && i_bus.wdata[`CTRL_STOP];
  wire clr_ovf   = wr_status && i_bus.wdata[`STAT_OVF];
  wire clr_lost  = wr_status && i_bus.wdata[`STAT_LOST];

  // mode decode
  wire width_mode = (cfg_reg.kind == KIND_WIDTH);
  wire large_mode = !width_mode && (cfg_reg.freq_method_select == METH_LARGE_RANGE);
  wire high_mode  = !width_mode && (cfg_reg.freq_method_select == METH_HIGH_FREQ);
  wire on_demand  = (cfg_reg.timing == TIME_ON_DEMAND);
  wire buffered   = !on_demand;

  // signal-to-measure routing; period and frequency share one path [R11] [R20]
  wire [`TERM_SEL_W-1:0] in_idx =
    width_mode ? cfg_reg.width_input_select :
    (cfg_reg.kind == KIND_PERIOD) ? cfg_reg.period_input_select :
    cfg_reg.freq_input_select;
  wire in_invert = width_mode && cfg_reg.width_start_edge; // [R14]
  wire act_now   = term_sync_reg[in_idx] ^ in_invert;
  wire act_prev  = term_prev_reg[in_idx] ^ in_invert;
  // only transitions start anything, so a pulse already in progress is skipped [R13] [R19]
  wire act_rise  = act_now && !act_prev;
  wire act_fall  = !act_now && act_prev;

  // timebase: system clock stands in for the onboard timebase, or a terminal edge [R2] [R20]
  wire                  tb_internal = (cfg_reg.timebase_source_select == `TB_INTERNAL);
  wire [`TERM_SEL_W-1:0] tb_idx     = `TERM_SEL_W'(cfg_reg.timebase_source_select - 4'h1);
  wire tb_tick = tb_internal || (term_sync_reg[tb_idx] && !term_prev_reg[tb_idx]);
  wire [`CNT_W-1:0] tb_tick_w = {{(`CNT_W-1){1'b0}}, tb_tick};

  // arm start trigger edge, polarity high selects the falling edge [R18]
  wire arm_now  = term_sync_reg[cfg_reg.arm_trigger_source] ^ cfg_reg.arm_trigger_polarity;
  wire arm_prev = term_prev_reg[cfg_reg.arm_trigger_source] ^ cfg_reg.arm_trigger_polarity;
  wire arm_hit  = arm_now && !arm_prev;

  // sample clock, rising edge active
  wire samp_hit = term_sync_reg[cfg_reg.sample_clock_select] &&
                  !term_prev_reg[cfg_reg.sample_clock_select];

  // a divide or gate of zero is taken as one, so a measurement spans at least one period or tick
  wire [`CNT_W-1:0] div_eff  = (divide_reg == `CNT_ZERO) ? `CNT_ONE : divide_reg;
  wire [`CNT_W-1:0] gate_eff = (gate_time_reg == `CNT_ZERO) ? `CNT_ONE : gate_time_reg;

  // the high-frequency gate starts at once, the other methods on an input edge
  wire state_t first_state = high_mode ? ST_MEAS : ST_SYNC;

  // result buffer state
  wire fifo_empty = (wr_ptr_reg == rd_ptr_reg);
  wire fifo_full  = (wr_ptr_reg[`FIFO_AW] != rd_ptr_reg[`FIFO_AW]) &&
                    (wr_ptr_reg[`FIFO_AW-1:0] == rd_ptr_reg[`FIFO_AW-1:0]);
  wire head_ok    = !fifo_empty && !stale_reg;
  // implicit pushes every result, the sample clock only once a result exists [R16] [R17]
  wire push_req   = (cfg_reg.timing == TIME_IMPLICIT) ? done :
                    ((cfg_reg.timing == TIME_SAMPLE) && samp_hit && have_res_reg && (state_reg != ST_IDLE));
  wire push_ok    = push_req && !fifo_full;
  wire lost_set   = push_req && fifo_full; // [R21]
  wire pop        = rd_res_a && buffered && head_ok;
  wire result_t push_data = (cfg_reg.timing == TIME_SAMPLE) ? res_reg : res_next;

  assign rd_ptr_next = start_cmd ? {(`FIFO_AW+1){1'b0}} :
                       (rd_ptr_reg + {{`FIFO_AW{1'b0}}, pop});

  // two flip-flops on every terminal before any logic looks at it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      term_meta_reg <= {`TERM_N{1'b0}};
      term_sync_reg <= {`TERM_N{1'b0}};
      term_prev_reg <= {`TERM_N{1'b0}};
    end else begin
      term_meta_reg <= i_terminals;
      term_sync_reg <= term_meta_reg;
      term_prev_reg <= term_sync_reg;
    end
  end

  // software settings
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_reg       <= config_t'(`CFG_RESET);
      divide_reg    <= `DIV_RESET;
      gate_time_reg <= `GATE_RESET;
    end else begin
      if (wr_config) begin
        cfg_reg <= config_t'(i_bus.wdata[`CFG_W-1:0]);
      end
      if (wr_divide) begin
        divide_reg <= i_bus.wdata; // [R6]
      end
      if (wr_gate) begin
        gate_time_reg <= i_bus.wdata; // [R10]
      end
    end
  end

  // measurement sequence
  always_comb begin
    state_next   = state_reg;
    tb_cnt_next  = `CNT_ZERO;
    per_cnt_next = `CNT_ZERO;
    res_next     = res_reg;
    done         = 1'b0;
    ovf_set      = 1'b0;
    // saturate rather than wrap so a long pulse cannot alias to a short one
    if (tb_tick && (tb_cnt_reg == `CNT_MAX)) begin
      tb_inc  = tb_cnt_reg;
      ovf_set = (state_reg == ST_MEAS); // [R21]
    end else begin
      tb_inc = tb_cnt_reg + tb_tick_w;
    end
    case (state_reg)
      ST_IDLE: begin
        if (start_cmd) begin
          state_next = cfg_reg.arm_trigger_type ? ST_ARM : first_state; // [R18]
        end
      end
      ST_ARM: begin
        if (arm_hit) begin
          state_next = first_state; // [R19]
        end
      end
      ST_SYNC: begin
        if (act_rise) begin
          state_next  = ST_MEAS;
          tb_cnt_next = tb_tick_w; // [R13]
        end
      end
      ST_MEAS: begin
        tb_cnt_next  = tb_inc;
        per_cnt_next = per_cnt_reg;
        if (width_mode) begin
          if (act_fall) begin
            done     = 1'b1;
            res_next = '{divided_period_count: `CNT_ZERO,
                         timebase_cycle_count: tb_cnt_reg}; // [R12]
          end
        end else if (high_mode) begin
          per_cnt_next = per_cnt_reg + {{(`CNT_W-1){1'b0}}, act_rise}; // [R9]
          if (tb_inc >= gate_eff) begin
            done     = 1'b1; // [R8]
            res_next = '{divided_period_count: per_cnt_next,
                         timebase_cycle_count: tb_inc};
          end
        end else if (act_rise) begin
          per_cnt_next = per_cnt_reg + `CNT_ONE; // [R3]
          if (!large_mode || (per_cnt_next >= div_eff)) begin
            done     = 1'b1; // [R1] [R4]
            res_next = '{divided_period_count: per_cnt_next,
                         timebase_cycle_count: tb_cnt_reg}; // [R5]
          end
        end
        if (done) begin
          per_cnt_next = `CNT_ZERO;
          if (on_demand) begin
            state_next  = ST_HOLD; // [R15]
            tb_cnt_next = `CNT_ZERO;
          end else if (width_mode) begin
            state_next  = ST_SYNC;
            tb_cnt_next = `CNT_ZERO;
          end else if (high_mode) begin
            state_next  = ST_MEAS;
            tb_cnt_next = `CNT_ZERO;
          end else begin
            // the closing edge opens the next period
            state_next  = ST_MEAS;
            tb_cnt_next = tb_tick_w;
          end
        end
      end
      ST_HOLD: begin
        if (rd_res_a) begin
          state_next = first_state; // [R15]
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (stop_cmd) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg   <= ST_IDLE;
      tb_cnt_reg  <= `CNT_ZERO;
      per_cnt_reg <= `CNT_ZERO;
      res_reg     <= result_t'(`RES_W'h0);
      gate_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      tb_cnt_reg  <= tb_cnt_next;
      per_cnt_reg <= per_cnt_next;
      res_reg     <= start_cmd ? result_t'(`RES_W'h0) : res_next;
      // gate of one counter of the fixed pair drives the other [R3] [R7] [R8]
      gate_reg    <= (state_next == ST_MEAS) && (large_mode || high_mode);
    end
  end

  // flags: a hardware set in the same cycle as a software clear wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      have_res_reg <= 1'b0;
      ovf_reg      <= 1'b0;
      lost_reg     <= 1'b0;
    end else begin
      have_res_reg <= done || (have_res_reg && !start_cmd);
      ovf_reg      <= ovf_set || (ovf_reg && !clr_ovf); // [R21]
      lost_reg     <= lost_set || (lost_reg && !clr_lost); // [R21]
    end
  end

  // buffer pointers; a word pushed into the slot being read is stale for one cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= {(`FIFO_AW+1){1'b0}};
      rd_ptr_reg <= {(`FIFO_AW+1){1'b0}};
      stale_reg  <= 1'b0;
    end else begin
      if (start_cmd) begin
        wr_ptr_reg <= {(`FIFO_AW+1){1'b0}};
      end else if (push_ok) begin
        wr_ptr_reg <= wr_ptr_reg + {{`FIFO_AW{1'b0}}, 1'b1}; // [R16] [R17]
      end
      rd_ptr_reg <= rd_ptr_next;
      stale_reg  <= push_ok && !start_cmd &&
                    (wr_ptr_reg[`FIFO_AW-1:0] == rd_ptr_next[`FIFO_AW-1:0]);
    end
  end

  cnt_result_mem u_mem (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_wr_en   (push_ok && !start_cmd),
    .i_wr_addr (wr_ptr_reg[`FIFO_AW-1:0]),
    .i_wr_data (push_data),
    .i_rd_addr (rd_ptr_next[`FIFO_AW-1:0]),
    .o_rd_data (head_data)
  );

  // read side: held result on demand, buffer head otherwise
  wire result_t out_res  = on_demand ? res_reg : head_data;
  wire          out_ok   = on_demand ? (state_reg == ST_HOLD) : head_ok;
  wire [`DATA_W-1:0] status_word = {{(`DATA_W-5){1'b0}}, fifo_empty, lost_reg, ovf_reg,
                                    out_ok, (state_reg != ST_IDLE)};

  always_comb begin
    rd_mux = {`DATA_W{1'b0}};
    case (i_bus.addr)
      `OFF_CONFIG:   rd_mux = {{(`DATA_W-`CFG_W){1'b0}}, cfg_reg};
      `OFF_DIVIDE:   rd_mux = divide_reg;
      `OFF_GATE:     rd_mux = gate_time_reg;
      `OFF_STATUS:   rd_mux = status_word;
      `OFF_RESULT_A: rd_mux = out_ok ? out_res.timebase_cycle_count : `CNT_ZERO; // [R5]
      `OFF_RESULT_B: rd_mux = out_ok ? out_res.divided_period_count : `CNT_ZERO; // [R5]
      default:       rd_mux = {`DATA_W{1'b0}};
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= {`DATA_W{1'b0}};
    end else begin
      o_rd_data <= i_bus.rd ? rd_mux : {`DATA_W{1'b0}};
    end
  end

  assign o_gate = gate_reg;
  assign o_busy = (state_reg != ST_IDLE);

endmodule

// ===== sig_model.sv
// stand-in for the external source of the signal to be measured
`include "cnt_meas_regs.svh"
module sig_model (
  // clock
  input  wire logic               i_clk,
  // driven terminals
  output logic [`TERM_N-1:0]      o_terms
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sig = 1'b0;
  int   sel = 0;
  // only the selected terminal carries the signal, the rest stay low
  assign o_terms = {7'h0, sig} << sel;
  // level changes just after an edge and holds for n cycles
  task automatic drive(input logic level, input int n);
    @(posedge i_clk);
    sig <= level;
    repeat (n - 1) @(posedge i_clk);
  endtask
endmodule

// ===== counter_freq_pulse_measure_sva.sv
// port-level assertions for the measurement counter pair
`include "cnt_meas_regs.svh"
module counter_freq_pulse_measure_sva (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // watched ports
  input  wire cnt_meas_pkg::bus_req_t i_bus,
  input  wire logic [`DATA_W-1:0]     o_rd_data,
  input  wire logic [`TERM_N-1:0]     i_terminals,
  input  wire logic                   o_gate,
  input  wire logic                   o_busy
);
  import cnt_meas_pkg::*;
  wire ctrl_w  = i_bus.wr && i_bus.addr == `OFF_CTRL;
  wire start_w = ctrl_w && i_bus.wdata[`CTRL_START] && !i_bus.wdata[`CTRL_STOP];
  wire stop_w  = ctrl_w && i_bus.wdata[`CTRL_STOP];
  wire stat_r  = i_bus.rd && i_bus.addr == `OFF_STATUS;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_rd_idle_zero: assert property (!i_bus.rd |=> o_rd_data == '0)
    else $error("read data not zero outside a read answer");
  chk_unmapped_zero: assert property (i_bus.rd && i_bus.addr >= 8'h1c |=> o_rd_data == '0)
    else $error("unmapped read returned data");
  chk_start_busy: assert property (start_w |=> o_busy)
    else $error("start did not leave idle");
  chk_busy_cause: assert property ($rose(o_busy) |-> $past(start_w))
    else $error("busy rose without a start");
  chk_stop_idle: assert property (stop_w |=> !o_busy && !o_gate)
    else $error("stop did not return to idle");
  chk_gate_busy: assert property (o_gate |-> o_busy)
    else $error("gate open while idle");
  chk_status_busy: assert property (stat_r |=> o_rd_data[`STAT_BUSY] == $past(o_busy))
    else $error("status busy bit disagrees with busy");
  chk_status_hi_zero: assert property (stat_r |=> o_rd_data[31:5] == '0)
    else $error("status upper bits not zero");
  chk_reset_quiet: assert property (disable iff (1'b0) i_rst |-> !o_busy && !o_gate && o_rd_data == '0)
    else $error("outputs active during reset");
endmodule

bind counter_freq_pulse_measure counter_freq_pulse_measure_sva u_counter_freq_pulse_measure_sva (
  .i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rd_data(o_rd_data),
  .i_terminals(i_terminals), .o_gate(o_gate), .o_busy(o_busy));

// ===== counter_freq_pulse_measure_test.sv
// self-checking bench for the measurement counter pair
`include "cnt_meas_regs.svh"
module counter_freq_pulse_measure_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cnt_meas_pkg::*;
  logic               i_clk;
  logic               i_rst;
  bus_req_t           bus;
  logic [`DATA_W-1:0] rd_data;
  logic [`TERM_N-1:0] model_terms;
  logic [`TERM_N-1:0] arm_terms;
  logic               gate;
  logic               busy;
  logic               gate_seen;
  int                 num_errors = 0;
  int                 n_checks = 0;
  logic [31:0]        ra;
  logic [31:0]        rb;
  config_t            c;

  counter_freq_pulse_measure u_counter_freq_pulse_measure (
    .i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_rd_data(rd_data),
    .i_terminals(model_terms | arm_terms), .o_gate(gate), .o_busy(busy));
  sig_model u_sig_model (.i_clk(i_clk), .o_terms(model_terms));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (gate === 1'b1) gate_seen <= 1'b1;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic run(input config_t cf);
    wr_reg(`OFF_CONFIG, {4'h0, cf});
    wr_reg(`OFF_CTRL, 32'h1);
  endtask
  task automatic get_res();
    int i;
    logic [31:0] s;
    s = '0;
    for (i = 0; i < 300 && s[`STAT_VALID] !== 1'b1; i++) rd_reg(`OFF_STATUS, s);
    chk("result valid", 1, s[`STAT_VALID]);
    rd_reg(`OFF_RESULT_B, rb);
    rd_reg(`OFF_RESULT_A, ra);
  endtask
  task automatic mk(input meas_kind_t k, input freq_method_t m, input timing_t t);
    c = '0;
    c.kind = k;
    c.freq_method_select = m;
    c.timing = t;
    wr_reg(`OFF_CTRL, 32'h2);
  endtask

  task automatic t_reset();
    rd_reg(`OFF_CONFIG, ra); chk("config", 0, ra);
    rd_reg(`OFF_DIVIDE, ra); chk("divide", 1, ra);
    rd_reg(`OFF_GATE, ra); chk("gate time", `GATE_RESET, ra);
    rd_reg(`OFF_STATUS, ra); chk("status", 32'h10, ra);
    wr_reg(8'h40, 32'hffffffff);
    rd_reg(8'h40, ra); chk("unmapped", 0, ra);
    rd_reg(`OFF_CTRL, ra); chk("ctrl", 0, ra);
    rd_reg(`OFF_CONFIG, ra); chk("config kept", 0, ra);
    $display("t_reset done");
  endtask
  task automatic t_ondemand();
    mk(KIND_WIDTH, METH_LOW_ONE, TIME_ON_DEMAND);
    u_sig_model.drive(1, 2);
    run(c);
    u_sig_model.drive(1, 4); u_sig_model.drive(0, 4);
    u_sig_model.drive(1, 5); u_sig_model.drive(0, 4);
    u_sig_model.drive(1, 7); u_sig_model.drive(0, 4);
    get_res();
    chk("width b", 0, rb);
    chk("width first", 5, ra);
    u_sig_model.drive(1, 4); u_sig_model.drive(0, 4);
    get_res();
    chk("width after read", 4, ra);
    $display("t_ondemand done");
  endtask
  task automatic t_implicit_fall();
    mk(KIND_WIDTH, METH_LOW_ONE, TIME_IMPLICIT);
    c.width_start_edge = 1'b1;
    run(c);
    u_sig_model.drive(0, 3); u_sig_model.drive(1, 4);
    u_sig_model.drive(0, 6); u_sig_model.drive(1, 3);
    u_sig_model.drive(0, 2); u_sig_model.drive(1, 4);
    get_res(); chk("low width 1", 6, ra);
    get_res(); chk("low width 2", 2, ra);
    rd_reg(`OFF_STATUS, rb); chk("empty", 1, rb[`STAT_EMPTY]);
    $display("t_implicit_fall done");
  endtask
  task automatic t_arm();
    mk(KIND_WIDTH, METH_LOW_ONE, TIME_ON_DEMAND);
    c.arm_trigger_type = 1'b1;
    c.arm_trigger_source = 3'h1;
    run(c);
    u_sig_model.drive(1, 5); u_sig_model.drive(0, 3);
    chk("waiting for arm", 1, busy);
    u_sig_model.drive(1, 2);
    @(posedge i_clk) arm_terms <= 8'h02;
    u_sig_model.drive(1, 3); u_sig_model.drive(0, 3);
    u_sig_model.drive(1, 4); u_sig_model.drive(0, 3);
    get_res(); chk("armed width", 4, ra);
    arm_terms <= 8'h00;
    $display("t_arm done");
  endtask
  task automatic t_period_low();
    mk(KIND_PERIOD, METH_LOW_ONE, TIME_ON_DEMAND);
    c.period_input_select = 3'h3;
    c.freq_input_select = 3'h3;
    u_sig_model.sel = 3;
    run(c);
    u_sig_model.drive(0, 3); u_sig_model.drive(1, 3);
    u_sig_model.drive(0, 5); u_sig_model.drive(1, 3); u_sig_model.drive(0, 5);
    get_res();
    chk("period ticks", 8, ra);
    chk("period count", 1, rb);
    $display("t_period_low done");
  endtask
  task automatic t_large();
    mk(KIND_FREQ, METH_LARGE_RANGE, TIME_ON_DEMAND);
    c.freq_input_select = 3'h3;
    wr_reg(`OFF_DIVIDE, 3);
    rd_reg(`OFF_DIVIDE, ra); chk("divide", 3, ra);
    gate_seen <= 1'b0;
    run(c);
    repeat (4) begin
      u_sig_model.drive(1, 2);
      u_sig_model.drive(0, 4);
    end
    get_res();
    chk("large ticks", 18, ra);
    chk("large periods", 3, rb);
    chk("divided gate", 1, gate_seen);
    $display("t_large done");
  endtask
  task automatic t_high();
    mk(KIND_FREQ, METH_HIGH_FREQ, TIME_ON_DEMAND);
    c.freq_input_select = 3'h3;
    wr_reg(`OFF_GATE, 40);
    gate_seen <= 1'b0;
    run(c);
    repeat (25) begin
      u_sig_model.drive(1, 2);
      u_sig_model.drive(0, 2);
    end
    get_res();
    chk("gate ticks", 40, ra);
    chk("edges in gate", 1, rb >= 9 && rb <= 11);
    chk("timed gate", 1, gate_seen);
    $display("t_high done");
  endtask
  task automatic t_lost();
    mk(KIND_WIDTH, METH_LOW_ONE, TIME_IMPLICIT);
    c.width_input_select = 3'h3;
    run(c);
    repeat (18) begin
      u_sig_model.drive(1, 2);
      u_sig_model.drive(0, 2);
    end
    rd_reg(`OFF_STATUS, ra);
    chk("lost set", 1, ra[`STAT_LOST]);
    chk("not empty", 0, ra[`STAT_EMPTY]);
    wr_reg(`OFF_STATUS, 32'h8);
    rd_reg(`OFF_STATUS, ra); chk("lost cleared", 0, ra[`STAT_LOST]);
    $display("t_lost done");
  endtask

  task automatic t_sample();
    mk(KIND_WIDTH, METH_LOW_ONE, TIME_SAMPLE);
    c.width_input_select = 3'h3;
    c.sample_clock_select = 3'h1;
    run(c);
    u_sig_model.drive(1, 3); u_sig_model.drive(0, 2);
    u_sig_model.drive(1, 5); u_sig_model.drive(0, 4);
    @(posedge i_clk) arm_terms <= 8'h02;
    get_res(); chk("sampled width", 5, ra);
    rd_reg(`OFF_STATUS, rb); chk("one per sample edge", 1, rb[`STAT_EMPTY]);
    arm_terms <= 8'h00;
    $display("t_sample done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    i_rst = 1'b0;
    bus = '0;
    arm_terms = '0;
    gate_seen = 1'b0;
    // a clean rising reset edge clears every flop except the result memory words before the first clock edge is checked
    #10 i_rst = 1'b1;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_ondemand();
    t_implicit_fall();
    t_arm();
    t_period_low();
    t_large();
    t_high();
    t_lost();
    t_sample();
    end_sim();
  end
  // the tests need well under 5000 cycles; this cuts a hang short
  initial begin
    #2000000;
    num_errors++;
    end_sim();
  end
endmodule
